// [logic/uspi_pkg.sv]
// Summary of operation
// - Protocol bit selects asynchronous or shift mode.
// - Characters are seven or eight bits long.
// - Master select makes us drive the clock.
// - Master drives out bit, samples mid-period.
// - Load shift register when empty, MSB first.
// - Receive MSB first, opposite edge to transmit.
// - Full character goes right-justified, sets ready.
// - Seven-bit mode reads holding MSB as zero.
// - Unread previous character sets overrun error.
// - Master receives only while a character transmits.
// - Master spends two hidden cycles between characters.
// - Four-wire master releases pins while select low.
// - Select low sets conflict error and ready.
// - Select high restores master pin drivers.
// - Select pin is input when assigned here.
// - Three-wire mode ignores the select input.
// - Slave takes clock from pin, not generator.
// - Slave shifts preloaded data, captures opposite edge.
// - Four-wire slave enabled only while select low.
// - Slave pauses on select high, then resumes.
// - Slave releases its output while select high.
// - One generator, one enable for both directions.
// - Transmit-empty set when buffer free, cleared on write.
// - Ready clears on service or buffer read.
package uspi_pkg;

  localparam int          ADDR_W    = 5;
  localparam logic [4:0]  OFS_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_DIV   = 5'h04;
  localparam logic [4:0]  OFS_STAT  = 5'h08;
  localparam logic [4:0]  OFS_TXBUF = 5'h0C;
  localparam logic [4:0]  OFS_RX_HOLDING_BUFFER_ALIAS = 5'h10;

  localparam int          B_SYNC    = 0;
  localparam int          B_MST     = 1;
  localparam int          B_CHAR8   = 2;
  localparam int          B_FOURW   = 3;
  localparam int          B_CPOL    = 4;
  localparam int          B_CPHA    = 5;
  localparam int          B_EN      = 6;
  localparam int          B_PSEL    = 7;

  localparam int          S_RXRDY   = 0;
  localparam int          S_TXEMPTY = 1;
  localparam int          S_OVR     = 2;
  localparam int          S_BCE     = 3;
  localparam int          S_BUSY    = 4;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] DIV_RST   = 16'h0003;
  localparam logic [3:0]  PIN_RST   = 4'h8;
  localparam logic [3:0]  BITS_7    = 4'h7;
  localparam logic [3:0]  BITS_8    = 4'h8;

  typedef enum logic [2:0] {M_IDLE, M_LEAD, M_TRAIL, M_GAP1, M_GAP2} uspi_mst_e;

endpackage

// [logic/uspi_shifter.sv]
`timescale 1ns/1ps
module uspi_shifter
  import uspi_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        ce,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic       [31:0] hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire  logic        serial_shift_clock_in,
  output logic              serial_shift_clock_out,
  output logic              serial_shift_clock_oe_n,
  input  wire  logic        master_out_line_in,
  output logic              master_out_line_out,
  output logic              master_out_line_oe_n,
  input  wire  logic        slave_out_line_in,
  output logic              slave_out_line_out,
  output logic              slave_out_line_oe_n,
  input  wire  logic        bus_select_line_in
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0]       main_control_reg_ff;
  logic [DIV_W-1:0] div_ff;
  logic [7:0]       txh_ff;
  logic             txfull_ff;
  logic [7:0]       rxh_ff;
  logic             rxrdy_ff;
  logic             ovr_ff;
  logic             bce_ff;
  logic             busy_ff;
  logic [7:0]       txsh_ff;
  logic [7:0]       rxsh_ff;
  logic [3:0]       bitcnt_ff;
  logic [DIV_W-1:0] divcnt_ff;
  uspi_mst_e        st_ff;
  logic             dout_ff;
  logic             sclk_o_ff;
  logic             sclk_oe_n_ff;
  logic             mo_oe_n_ff;
  logic             so_oe_n_ff;
  logic [3:0]       s1_ff;
  logic [3:0]       s2_ff;
  logic [3:0]       s3_ff;
  logic [3:0]       f_ff;
  logic             sclk_d_ff;
  logic             wr_ph_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0]      hrdata_ff;
  logic             hready_ff;
  logic             hresp_ff;

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic ap;
  logic rd_rx;
  logic wr_ctrl;
  logic wr_div;
  logic wr_stat;
  logic wr_tx;

  assign ap      = hsel && htrans[1] && hready;
  assign rd_rx   = ap && !hwrite && haddr[ADDR_W-1:0] == OFS_RX_HOLDING_BUFFER_ALIAS;
  assign wr_ctrl = wr_ph_ff && addr_ff == OFS_CTRL;
  assign wr_div  = wr_ph_ff && addr_ff == OFS_DIV;
  assign wr_stat = wr_ph_ff && addr_ff == OFS_STAT;
  assign wr_tx   = wr_ph_ff && addr_ff == OFS_TXBUF;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      addr_ff  <= '0;
    end else if (ce) begin
      if (hready) begin
        wr_ph_ff <= ap && hwrite;
        addr_ff  <= haddr[ADDR_W-1:0];
      end
    end
  end

  // Read data is formed in the address phase so it stands registered
  // for the data phase; a write in the same cycle is not yet visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (ce) begin
      if (ap && !hwrite) begin
        unique case (haddr[ADDR_W-1:0])
          OFS_CTRL:  hrdata_ff <= {24'h000000, main_control_reg_ff};
          OFS_DIV:   hrdata_ff <= 32'(div_ff);
          OFS_STAT:  hrdata_ff <= {27'h0000000, busy_ff, bce_ff, ovr_ff,
                                   !txfull_ff, rxrdy_ff};
          OFS_TXBUF: hrdata_ff <= {24'h000000, txh_ff};
          OFS_RX_HOLDING_BUFFER_ALIAS: hrdata_ff <= {24'h000000, rxh_ff};
          default:   hrdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_ff <= 1'b1;
      hresp_ff  <= 1'b0;
    end else if (ce) begin
      hready_ff <= 1'b1;
      hresp_ff  <= 1'b0;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp     = hresp_ff;

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_control_reg_ff <= CTRL_RST;
      div_ff              <= DIV_W'(DIV_RST);
    end else if (ce) begin
      if (wr_ctrl) begin
        main_control_reg_ff <= hwdata[7:0];
      end
      if (wr_div) begin
        div_ff <= hwdata[DIV_W-1:0];
      end
    end
  end

  logic       sync_on;
  logic       mst;
  logic       c8;
  logic       cpol;
  logic       cpha;
  logic       en;
  logic       ste_used;
  logic       m_role;
  logic       s_role;
  logic [3:0] nbits;
  logic       last;

  assign sync_on  = main_control_reg_ff[B_SYNC];
  assign mst      = main_control_reg_ff[B_MST];
  assign c8       = main_control_reg_ff[B_CHAR8];
  assign cpol     = main_control_reg_ff[B_CPOL];
  assign cpha     = main_control_reg_ff[B_CPHA];
  assign en       = main_control_reg_ff[B_EN];
  assign ste_used = sync_on && main_control_reg_ff[B_FOURW]
                    && main_control_reg_ff[B_PSEL];
  assign m_role   = sync_on && mst;
  assign s_role   = sync_on && !mst;
  assign nbits    = c8 ? BITS_8 : BITS_7;
  assign last     = bitcnt_ff == nbits - 4'h1;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] pins;
  logic [3:0] agree;

  assign pins  = {bus_select_line_in, slave_out_line_in,
                  master_out_line_in, serial_shift_clock_in};
  assign agree = ~(s2_ff ^ s3_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff     <= PIN_RST;
      s2_ff     <= PIN_RST;
      s3_ff     <= PIN_RST;
      f_ff      <= PIN_RST;
      sclk_d_ff <= 1'b0;
    end else if (ce) begin
      s1_ff     <= pins;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      f_ff      <= (s3_ff & agree) | (f_ff & ~agree);
      sclk_d_ff <= f_ff[0];
    end
  end

  logic sclk_f;
  logic mo_f;
  logic so_f;
  logic ste_f;

  assign sclk_f = f_ff[0];
  assign mo_f   = f_ff[1];
  assign so_f   = f_ff[2];
  assign ste_f  = f_ff[3];

  // ------------------------------------------------------------------
  // Role gating and shift events
  // ------------------------------------------------------------------
  logic conflict;
  logic s_on;
  logic tick;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic ev_lead;
  logic ev_trail;
  logic load;
  logic fin;
  logic emit;
  logic samp;
  logic din;

  assign conflict = m_role && ste_used && !ste_f;
  assign s_on     = s_role && en && (!ste_used || !ste_f);
  assign tick     = divcnt_ff == div_ff;
  assign m_lead   = st_ff == M_LEAD && tick && !conflict;
  assign m_trail  = st_ff == M_TRAIL && tick && !conflict;
  assign s_lead   = s_on && sclk_f != sclk_d_ff && sclk_f != cpol;
  assign s_trail  = s_on && sclk_f != sclk_d_ff && sclk_f == cpol;
  assign ev_lead  = m_role ? m_lead : s_lead;
  assign ev_trail = m_role ? m_trail : s_trail;
  // A character is only started with the buffer full and the enable set.
  assign load     = !busy_ff && txfull_ff && en && bitcnt_ff == 4'h0
                    && (m_role ? (st_ff == M_IDLE && !conflict) : s_role);
  assign fin      = bitcnt_ff == nbits && (!m_role || st_ff == M_GAP2);
  assign emit     = (ev_lead && cpha) || (ev_trail && !cpha && !last);
  assign samp     = (ev_lead && !cpha) || (ev_trail && cpha);
  assign din      = m_role ? so_f : mo_f;

  // ------------------------------------------------------------------
  // Master sequencer and bit-rate generator
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= M_IDLE;
    end else if (ce) begin
      if (!m_role) begin
        st_ff <= M_IDLE;
      end else begin
        unique case (st_ff)
          M_IDLE: begin
            if (load) begin
              st_ff <= M_LEAD;
            end
          end
          M_LEAD: begin
            if (m_lead) begin
              st_ff <= M_TRAIL;
            end
          end
          M_TRAIL: begin
            if (m_trail) begin
              st_ff <= last ? M_GAP1 : M_LEAD;
            end
          end
          M_GAP1: begin
            st_ff <= M_GAP2;
          end
          M_GAP2: begin
            st_ff <= M_IDLE;
          end
        endcase
      end
    end
  end

  // One half-period counter serves both directions.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      divcnt_ff <= '0;
    end else if (ce) begin
      if ((st_ff == M_LEAD || st_ff == M_TRAIL) && !conflict && !tick) begin
        divcnt_ff <= divcnt_ff + DIV_W'(1);
      end else if (!conflict) begin
        divcnt_ff <= '0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_o_ff <= 1'b0;
    end else if (ce) begin
      if (!m_role || st_ff == M_IDLE) begin
        sclk_o_ff <= cpol;
      end else if (m_lead || m_trail) begin
        sclk_o_ff <= !sclk_o_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // Shift registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txsh_ff <= 8'h00;
      dout_ff <= 1'b0;
    end else if (ce) begin
      if (load) begin
        txsh_ff <= cpha ? txh_ff : {txh_ff[6:0], 1'b0};
        if (!cpha) begin
          dout_ff <= c8 ? txh_ff[7] : txh_ff[6];
        end
      end else if (emit) begin
        dout_ff <= c8 ? txsh_ff[7] : txsh_ff[6];
        txsh_ff <= {txsh_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxsh_ff <= 8'h00;
    end else if (ce) begin
      if (samp) begin
        rxsh_ff <= {rxsh_ff[6:0], din};
      end
    end
  end

  // The bit count holds while a four-wire slave is deselected.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bitcnt_ff <= 4'h0;
    end else if (ce) begin
      if (!sync_on || fin) begin
        bitcnt_ff <= 4'h0;
      end else if (ev_trail) begin
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 1'b0;
    end else if (ce) begin
      if (!sync_on || fin) begin
        busy_ff <= 1'b0;
      end else if (load) begin
        busy_ff <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Holding buffers and status flags
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txh_ff    <= 8'h00;
      txfull_ff <= 1'b0;
    end else if (ce) begin
      if (wr_tx) begin
        txh_ff    <= hwdata[7:0];
        txfull_ff <= 1'b1;
      end else if (load) begin
        txfull_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxh_ff <= 8'h00;
    end else if (ce) begin
      if (fin) begin
        rxh_ff <= c8 ? rxsh_ff : {1'b0, rxsh_ff[6:0]};
      end
    end
  end

  // Setting events win over a clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxrdy_ff <= 1'b0;
    end else if (ce) begin
      if (fin || conflict) begin
        rxrdy_ff <= 1'b1;
      end else if (rd_rx || (wr_stat && hwdata[S_RXRDY])) begin
        rxrdy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_ff <= 1'b0;
    end else if (ce) begin
      if (fin && rxrdy_ff) begin
        ovr_ff <= 1'b1;
      end else if (wr_stat && hwdata[S_OVR]) begin
        ovr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bce_ff <= 1'b0;
    end else if (ce) begin
      if (conflict) begin
        bce_ff <= 1'b1;
      end else if (wr_stat && hwdata[S_BCE]) begin
        bce_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_oe_n_ff <= 1'b1;
      mo_oe_n_ff   <= 1'b1;
      so_oe_n_ff   <= 1'b1;
    end else if (ce) begin
      sclk_oe_n_ff <= !(m_role && !conflict);
      mo_oe_n_ff   <= !(m_role && !conflict);
      so_oe_n_ff   <= !(s_role && (!ste_used || !ste_f));
    end
  end

  assign serial_shift_clock_out  = sclk_o_ff;
  assign serial_shift_clock_oe_n = sclk_oe_n_ff;
  assign master_out_line_out     = dout_ff;
  assign master_out_line_oe_n    = mo_oe_n_ff;
  assign slave_out_line_out      = dout_ff;
  assign slave_out_line_oe_n     = so_oe_n_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_tx_empty_set: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    load && !wr_tx |=> !txfull_ff && busy_ff)
    else $error("buffer not freed after load");

  a_rx_copy: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    fin && c8 |=> rxh_ff == $past(rxsh_ff) && rxrdy_ff)
    else $error("received character not copied");

  a_rx_msb_zero: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    fin && !c8 |=> !rxh_ff[7])
    else $error("seven-bit character has msb set");

  a_overrun_set: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    fin && rxrdy_ff |=> ovr_ff)
    else $error("overrun not flagged");

  a_gap_two: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce || !m_role)
    m_trail && last |=> st_ff == M_GAP1 ##1 st_ff == M_GAP2 ##1 st_ff == M_IDLE)
    else $error("gap between characters not two cycles");

  a_master_busy: assert property (
    @(posedge hclk) disable iff (!hresetn)
    m_role && st_ff != M_IDLE |-> busy_ff)
    else $error("master shifting without a character");

  a_conflict_off: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    conflict |=> sclk_oe_n_ff && mo_oe_n_ff)
    else $error("master pins driven during conflict");

  a_conflict_flags: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    conflict |=> bce_ff && rxrdy_ff)
    else $error("conflict flags not set");

  a_slave_release: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    s_role && ste_used && ste_f |=> so_oe_n_ff)
    else $error("slave output driven while deselected");

  a_slave_pause: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    s_role && ste_used && ste_f && !fin |=> $stable(bitcnt_ff))
    else $error("deselected slave kept counting");

  a_rx_clear: assert property (
    @(posedge hclk) disable iff (!hresetn || !ce)
    rd_rx && !fin && !conflict |=> !rxrdy_ff)
    else $error("ready flag not cleared by read");

endmodule

// [sim/uspi_far_end.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Far-end serial device, slave or master.
// ----------------------------------------
module uspi_far_end (
  input  wire logic sclk_w,
  input  wire logic mo_w,
  input  wire logic so_w,
  input  wire logic cpol,
  input  wire logic cpha,
  output logic      sclk_drv,
  output logic      mo_drv,
  output logic      so_drv,
  output logic      sel_n
);
  logic [7:0] tx;
  logic [7:0] rx;
  int         n;
  int         k;
  int         s;
  logic       act;

  initial begin
    sclk_drv = 1'b0;
    mo_drv   = 1'b0;
    so_drv   = 1'b0;
    sel_n    = 1'b1;
    act      = 1'b0;
  end

  // Slave role: preload a character and answer the device's clock.
  task automatic arm(input logic [7:0] b, input int bits);
    tx  = b;
    n   = bits;
    k   = 0;
    s   = 0;
    rx  = 8'h00;
    act = 1'b1;
    if (!cpha) begin
      so_drv = b[bits-1];
    end
  endtask

  // A released line shows the inverse of its last bit, never a held value.
  always @(sclk_w) begin
    if (act) begin
      if ((sclk_w != cpol) ^ cpha) begin
        rx = {rx[6:0], mo_w};
        s++;
        if (s == n && cpha) begin
          act    = 1'b0;
          so_drv = ~so_drv;
        end
      end else begin
        if (!cpha) begin
          k++;
        end
        if (k < n) begin
          so_drv = tx[n-1-k];
        end else begin
          so_drv = ~so_drv;
          act    = 1'b0;
        end
        if (cpha) begin
          k++;
        end
      end
    end
  end

  // Master role: the clock idles between bits; a hold pulses it once with select high.
  task automatic run(input logic [7:0] b, input int bits, input int half, input int hold_at);
    rx = 8'h00;
    for (int i = 0; i < bits; i++) begin
      mo_drv = b[bits-1-i];
      #(half);
      sclk_drv = ~cpol;
      rx = {rx[6:0], so_w};
      #(half);
      sclk_drv = cpol;
      // Select moves half a period away from any clock edge.
      if (i == hold_at) begin
        #(half);
        sel_n = 1'b1;
        #(half);
        sclk_drv = ~cpol;
        #(half);
        sclk_drv = cpol;
        #(half);
        sel_n = 1'b0;
      end
    end
    #(half);
    mo_drv = ~mo_drv;
  endtask
endmodule

// [sim/usart_spi_mode_shifter_tb.sv]
`timescale 1ns/1ps
module usart_spi_mode_shifter_tb
  import uspi_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sc_out, sc_oe_n, mo_out, mo_oe_n, so_out, so_oe_n;
  logic        p_sc, p_mo, p_so, p_sel_n, cpol_v, cpha_v;
  int          bad_count, samples_checked;
  wire         sc_w = sc_oe_n ? p_sc : sc_out;
  wire         mo_w = mo_oe_n ? p_mo : mo_out;
  wire         so_w = so_oe_n ? p_so : so_out;

  uspi_shifter i_dut (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .ce                      (1'b1),
    .hsel                    (1'b1),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (3'h2),
    .hwdata                  (hwdata),
    .hready                  (hreadyout),
    .hrdata                  (hrdata),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .serial_shift_clock_in   (sc_w),
    .serial_shift_clock_out  (sc_out),
    .serial_shift_clock_oe_n (sc_oe_n),
    .master_out_line_in      (mo_w),
    .master_out_line_out     (mo_out),
    .master_out_line_oe_n    (mo_oe_n),
    .slave_out_line_in       (so_w),
    .slave_out_line_out      (so_out),
    .slave_out_line_oe_n     (so_oe_n),
    .bus_select_line_in      (p_sel_n)
  );

  uspi_far_end far (
    .sclk_w   (sc_w),
    .mo_w     (mo_w),
    .so_w     (so_w),
    .cpol     (cpol_v),
    .cpha     (cpha_v),
    .sclk_drv (p_sc),
    .mo_drv   (p_mo),
    .so_drv   (p_so),
    .sel_n    (p_sel_n)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ----------------------------------------
  // Bus and check helpers.
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_rdy();
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 100);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {27'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_stat(input int b);
    logic [31:0] q;
    int          t;
    t = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0, q);
      t++;
    end while (q[b] !== 1'b1 && t < 300);
    chk("status wait", 32'h1, {31'h0, q[b]});
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_reset();
    chk_rd("main_control_reg", OFS_CTRL, {24'h0, CTRL_RST});
    chk_rd("divider", OFS_DIV, {16'h0, DIV_RST});
    chk_rd("status", OFS_STAT, 32'h2);
    chk_rd("unmapped", 5'h14, 32'h0);
  endtask

  task automatic t_master(input logic [7:0] cfg, input logic [7:0] tx, input logic [7:0] sl);
    int         n;
    logic [7:0] m;
    n = cfg[B_CHAR8] ? 8 : 7;
    m = cfg[B_CHAR8] ? 8'hFF : 8'h7F;
    wr(OFS_CTRL, {24'h0, cfg});
    cpol_v = cfg[B_CPOL];
    cpha_v = cfg[B_CPHA];
    // Let the clock pin settle at its new idle level before the far end listens.
    repeat (2) @(posedge hclk);
    far.arm(sl, n);
    wr(OFS_TXBUF, {24'h0, tx});
    wait_stat(S_RXRDY);
    chk_rd("rx_holding_buffer", OFS_RX_HOLDING_BUFFER_ALIAS, {24'h0, sl & m});
    chk("far end rx", {24'h0, tx & m}, {24'h0, far.rx});
    chk_rd("status after read", OFS_STAT, 32'h2);
  endtask

  task automatic t_overrun();
    wr(OFS_CTRL, 32'h47);
    cpol_v = 1'b0;
    cpha_v = 1'b0;
    far.arm(8'h3C, 8);
    wr(OFS_TXBUF, 32'hA1);
    chk_rd("tx empty after load", OFS_STAT, 32'h12);
    wr(OFS_TXBUF, 32'h5E);
    chk_rd("tx empty after write", OFS_STAT, 32'h10);
    wait_stat(S_OVR);
    chk_rd("overrun", OFS_STAT, 32'h7);
    chk_rd("second char", OFS_RX_HOLDING_BUFFER_ALIAS, 32'hFF);
    wr(OFS_STAT, 32'h5);
    chk_rd("flags cleared", OFS_STAT, 32'h2);
  endtask

  task automatic t_conflict();
    logic [7:0] cfg [3];
    cfg = '{8'hCF, 8'h4F, 8'h47};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, {24'h0, cfg[i]});
      far.sel_n <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("clock pin release", {31'h0, i == 0}, {31'h0, sc_oe_n});
      chk("master out release", {31'h0, i == 0}, {31'h0, mo_oe_n});
      chk_rd("conflict flags", OFS_STAT, (i == 0) ? 32'hB : 32'h2);
      far.sel_n <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("clock pin restore", 32'h0, {31'h0, sc_oe_n});
      chk("master out restore", 32'h0, {31'h0, mo_oe_n});
      wr(OFS_STAT, 32'h9);
    end
  endtask

  task automatic t_slave(input logic [7:0] cfg, input logic [7:0] tx, input logic [7:0] mb,
                         input int hold_at);
    wr(OFS_CTRL, {24'h0, cfg});
    cpol_v = 1'b0;
    cpha_v = 1'b0;
    far.sel_n <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("slave out enable", {31'h0, cfg[B_FOURW]}, {31'h0, so_oe_n});
    wr(OFS_TXBUF, {24'h0, tx});
    far.sel_n <= 1'b0;
    far.run(mb, 8, 160, hold_at);
    wait_stat(S_RXRDY);
    chk_rd("slave rx", OFS_RX_HOLDING_BUFFER_ALIAS, {24'h0, mb});
    chk("master side rx", {24'h0, tx}, {24'h0, far.rx});
  endtask

  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cpol_v = 1'b0;
    cpha_v = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    // The half period must outlast the pin synchroniser for mid-period sampling.
    wr(OFS_DIV, 32'h7);
    t_master(8'h47, 8'hB0, 8'h5A);
    t_master(8'h43, 8'hE8, 8'h98);
    t_master(8'h57, 8'hC3, 8'h2D);
    t_master(8'h67, 8'h81, 8'h7E);
    t_overrun();
    t_conflict();
    t_slave(8'h45, 8'h3C, 8'hA5, -1);
    t_slave(8'hCD, 8'h96, 8'h69, 3);
    test_done();
  end

  // Cuts a hang short at 1.5 ms, far beyond the length of the whole run.
  initial begin
    #1500000;
    bad_count++;
    test_done();
  end
endmodule
